// [logic/tae_chan.sv]
// One 16-bit reload counter channel of the timer/event counter.
// Assumes the caller supplies one-cycle count steps and the direction.
`timescale 1ns/1ns
module tae_chan (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    input  wire logic                       start,
    input  wire logic                       step,
    input  wire logic                       up,
    input  wire tae_pkg::tae_mode_t         mode,
    input  wire logic                       free_run,
    input  wire logic                       pulse_en,
    input  wire logic                       wr,
    input  wire logic [tae_pkg::TAE_CW-1:0] wdata,
    output logic      [tae_pkg::TAE_CW-1:0] count,
    output logic      [tae_pkg::TAE_CW-1:0] rld,
    output logic                            out_lvl,
    output logic                            ovf
);

    tae_pkg::tae_chan_st_t q;
    tae_pkg::tae_chan_st_t d;
    logic                  wrap;
    logic                  keep_run;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d        = q;
        d.ovf    = 1'b0;
        wrap     = 1'b0;
        // Free-run only applies to event counting
        keep_run = free_run && (mode == tae_pkg::TAE_MODE_EVENT);
        if (wr) begin
            d.rld = wdata;
            if (!start) begin
                d.cnt = wdata;
            end
        end
        if (start && step) begin
            if (up) begin
                if (q.cnt == '1) begin
                    wrap  = 1'b1;
                    d.cnt = keep_run ? '0 : d.rld;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end else begin
                if (q.cnt == '0) begin
                    wrap  = 1'b1;
                    d.cnt = keep_run ? '1 : d.rld;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
        end
        if (wrap) begin
            d.ovf = 1'b1;
            if (pulse_en) begin
                d.out = ~q.out;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{cnt: tae_pkg::TAE_TMR_RST, rld: tae_pkg::TAE_TMR_RST,
                   out: 1'b0, ovf: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign count   = q.cnt;
    assign rld     = q.rld;
    assign out_lvl = q.out;
    assign ovf     = q.ovf;

endmodule // tae_chan

// [logic/tae_pkg.sv]
// Shared constants, register map and state types of the timer/event counter.
// Assumes a single 250 MHz clock and an AXI4-Lite master with 32-bit data.
package tae_pkg;

    localparam int          TAE_NCH        = 3;
    localparam int          TAE_CW         = 16;
    localparam int          TAE_AW         = 8;

    // Register map, byte addresses
    localparam logic [7:0]  TAE_CH_STRIDE  = 8'h10;
    localparam logic [3:0]  TAE_OFS_MODE   = 4'h0;
    localparam logic [3:0]  TAE_OFS_TMR    = 4'h4;
    localparam logic [7:0]  TAE_OFS_START  = 8'h30;
    localparam logic [7:0]  TAE_OFS_STAT   = 8'h34;

    // Reset values
    localparam logic [11:0] TAE_CFG_RST    = 12'h000;
    localparam logic [15:0] TAE_TMR_RST    = 16'h0000;
    localparam logic [2:0]  TAE_START_RST  = 3'h0;

    // Prescaler terminal counts
    localparam logic [2:0]  TAE_DIV8_LAST  = 3'h7;
    localparam logic [4:0]  TAE_DIV32_LAST = 5'h1f;

    localparam logic [1:0]  TAE_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  TAE_RESP_SLV   = 2'h2;

    typedef enum logic [1:0] {
        TAE_MODE_TIMER,
        TAE_MODE_EVENT,
        TAE_MODE_ONESHOT,
        TAE_MODE_PWM
    } tae_mode_t;

    typedef enum logic [2:0] {
        TAE_REG_NONE,
        TAE_REG_MODE,
        TAE_REG_TMR,
        TAE_REG_START,
        TAE_REG_STAT
    } tae_reg_t;

    // Mode register of one channel, mode field in bits 1:0
    typedef struct packed {
        logic      two_phase;
        logic      free_run;
        logic      dir_pin;
        logic      dir_up;
        logic      edge_fall;
        logic [1:0] src;
        logic      pulse_en;
        logic      gate_lvl;
        logic      gate_en;
        tae_mode_t mode;
    } tae_cfg_t;

    typedef struct packed {
        logic [TAE_CW-1:0] cnt;
        logic [TAE_CW-1:0] rld;
        logic              out;
        logic              ovf;
    } tae_chan_st_t;

    typedef struct packed {
        tae_cfg_t [2:0]    cfg;
        logic [2:0]        start;
        logic              aw_full;
        logic [7:0]        awaddr;
        logic              w_full;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [4:0]        presc;
        logic [2:0]        in_s1;
        logic [2:0]        in_s2;
        logic [2:0]        in_s3;
        logic [2:0]        op_s1;
        logic [2:0]        op_s2;
        logic              sub_s1;
        logic              sub_s2;
        logic              sub_s3;
        logic [4:0]        sub_cnt;
    } tae_top_st_t;

endpackage

// [logic/tae_top.sv]
// Three-channel 16-bit timer / event counter with an AXI4-Lite register port.
// Assumes pins and the sub-clock are asynchronous; the B-group overflow is
// a one-cycle pulse on aclk.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module tae_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timer pins and count sources
    input  wire logic [2:0]  chan_in_pin,
    input  wire logic [2:0]  chan_out_pin_i,
    output logic      [2:0]  chan_out_pin_o,
    output logic      [2:0]  chan_out_pin_oe,
    input  wire logic        subclk,
    input  wire logic        second_b_group_timer_ovf,
    output logic      [2:0]  irq_req
);

    tae_pkg::tae_top_st_t q;
    tae_pkg::tae_top_st_t d;

    logic [2:0]   step;
    logic [2:0]   up;
    logic [2:0]   wr_tmr;
    logic [15:0]  tmr_wdata;
    logic [15:0]  cnt_v [3];
    logic [15:0]  rld_v [3];
    logic [2:0]   out_lvl;
    logic [2:0]   ch_ovf;
    logic [3:0]   clk_tick;
    logic         sub_rise;
    logic [31:0]  merged;
    logic         rise;
    logic         fall;
    logic         ev_src;
    logic [1:0]   wch;
    logic [1:0]   rch;

    ////////////////////////////////////////////////////////////////////////
    // Register decode shared by the read and write paths
    function automatic tae_pkg::tae_reg_t reg_kind(input logic [7:0] a);
        reg_kind = tae_pkg::TAE_REG_NONE;
        if (a == tae_pkg::TAE_OFS_START) begin
            reg_kind = tae_pkg::TAE_REG_START;
        end else if (a == tae_pkg::TAE_OFS_STAT) begin
            reg_kind = tae_pkg::TAE_REG_STAT;
        end else if (a[7:6] == 2'h0 && a[5:4] != 2'h3) begin
            if (a[3:0] == tae_pkg::TAE_OFS_MODE) begin
                reg_kind = tae_pkg::TAE_REG_MODE;
            end else if (a[3:0] == tae_pkg::TAE_OFS_TMR) begin
                reg_kind = tae_pkg::TAE_REG_TMR;
            end
        end
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        strb_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                strb_merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus, prescaler and pin synchronisers
    always_comb begin
        d         = q;
        wr_tmr    = 3'h0;
        tmr_wdata = 16'h0000;
        merged    = 32'h0000_0000;
        wch       = q.awaddr[5:4];
        rch       = s_axi_araddr[5:4];

        // Address and data may arrive in either order
        if (s_axi_awvalid && !q.aw_full) begin
            d.aw_full = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_full) begin
            d.w_full = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // Hold the write until the previous response is gone
        if (q.aw_full && q.w_full && !q.bvalid) begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = tae_pkg::TAE_RESP_OKAY;
            case (reg_kind(q.awaddr))
                tae_pkg::TAE_REG_MODE: begin
                    merged      = strb_merge({20'h0, q.cfg[wch]}, q.wdata, q.wstrb);
                    d.cfg[wch]  = tae_pkg::tae_cfg_t'(merged[11:0]);
                end
                tae_pkg::TAE_REG_TMR: begin
                    merged      = strb_merge({16'h0, rld_v[wch]}, q.wdata, q.wstrb);
                    tmr_wdata   = merged[15:0];
                    wr_tmr[wch] = 1'b1;
                end
                tae_pkg::TAE_REG_START: begin
                    merged      = strb_merge({29'h0, q.start}, q.wdata, q.wstrb);
                    d.start     = merged[2:0];
                end
                tae_pkg::TAE_REG_STAT: begin
                    d.bresp     = tae_pkg::TAE_RESP_OKAY;
                end
                default: begin
                    d.bresp     = tae_pkg::TAE_RESP_SLV;
                end
            endcase
        end

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = tae_pkg::TAE_RESP_OKAY;
            case (reg_kind(s_axi_araddr))
                tae_pkg::TAE_REG_MODE:  d.rdata = {20'h0, q.cfg[rch]};
                tae_pkg::TAE_REG_TMR:   d.rdata = {16'h0, cnt_v[rch]};
                tae_pkg::TAE_REG_START: d.rdata = {29'h0, q.start};
                tae_pkg::TAE_REG_STAT:  d.rdata = {26'h0, q.in_s2, out_lvl};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = tae_pkg::TAE_RESP_SLV;
                end
            endcase
        end

        // Free-running prescaler feeds all channels
        d.presc  = q.presc + 5'h01;
        // First stage feeds only the second stage
        d.in_s1  = chan_in_pin;
        d.in_s2  = q.in_s1;
        d.in_s3  = q.in_s2;
        d.op_s1  = chan_out_pin_i;
        d.op_s2  = q.op_s1;
        d.sub_s1 = subclk;
        d.sub_s2 = q.sub_s1;
        d.sub_s3 = q.sub_s2;
        if (q.sub_s2 && !q.sub_s3) begin
            d.sub_cnt = q.sub_cnt + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count steps and directions per channel
    assign sub_rise = q.sub_s2 && !q.sub_s3;

    always_comb begin
        clk_tick[0] = 1'b1;
        clk_tick[1] = (q.presc[2:0] == tae_pkg::TAE_DIV8_LAST);
        clk_tick[2] = (q.presc == tae_pkg::TAE_DIV32_LAST);
        clk_tick[3] = sub_rise && (q.sub_cnt == tae_pkg::TAE_DIV32_LAST);
    end

    always_comb begin
        step   = 3'h0;
        up     = 3'h0;
        rise   = 1'b0;
        fall   = 1'b0;
        ev_src = 1'b0;
        chan_out_pin_oe = 3'h0;
        for (int i = 0; i < 3; i++) begin
            rise = q.in_s2[i] && !q.in_s3[i];
            fall = !q.in_s2[i] && q.in_s3[i];
            case (q.cfg[i].mode)
                tae_pkg::TAE_MODE_TIMER: begin
                    // Gate compares the synchronised pin with its level bit
                    step[i] = clk_tick[q.cfg[i].src] &&
                              (!q.cfg[i].gate_en ||
                               q.in_s2[i] == q.cfg[i].gate_lvl);
                    up[i]   = 1'b0;
                    chan_out_pin_oe[i] = q.cfg[i].pulse_en;
                end
                tae_pkg::TAE_MODE_EVENT: begin
                    if (i == 2 && q.cfg[i].two_phase) begin
                        // Both pins are inputs here, output driver stays off
                        step[i] = (rise || fall) && q.op_s2[i];
                        up[i]   = rise;
                    end else begin
                        case (q.cfg[i].src)
                            2'h1:    ev_src = second_b_group_timer_ovf;
                            2'h2:    ev_src = ch_ovf[(i + 2) % 3];
                            default: ev_src = q.cfg[i].edge_fall ? fall : rise;
                        endcase
                        step[i] = ev_src;
                        up[i]   = q.cfg[i].dir_pin ? q.op_s2[i]
                                                   : q.cfg[i].dir_up;
                        chan_out_pin_oe[i] = q.cfg[i].pulse_en &&
                                             !q.cfg[i].dir_pin;
                    end
                end
                default: begin
                    step[i] = 1'b0;
                    up[i]   = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q         <= '0;
            q.cfg     <= {3{tae_pkg::TAE_CFG_RST}};
            q.start   <= tae_pkg::TAE_START_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels; channel two alone is wired for two-phase input
    for (genvar g = 0; g < 3; g++) begin : g_ch
        tae_chan u_chan (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .ce       (ce),
            .start    (q.start[g]),
            .step     (step[g]),
            .up       (up[g]),
            .mode     (q.cfg[g].mode),
            .free_run (q.cfg[g].free_run),
            .pulse_en (q.cfg[g].pulse_en),
            .wr       (wr_tmr[g]),
            .wdata    (tmr_wdata),
            .count    (cnt_v[g]),
            .rld      (rld_v[g]),
            .out_lvl  (out_lvl[g]),
            .ovf      (ch_ovf[g])
        );
    end

    assign s_axi_awready  = !q.aw_full;
    assign s_axi_wready   = !q.w_full;
    assign s_axi_bvalid   = q.bvalid;
    assign s_axi_bresp    = q.bresp;
    assign s_axi_arready  = !q.rvalid;
    assign s_axi_rvalid   = q.rvalid;
    assign s_axi_rdata    = q.rdata;
    assign s_axi_rresp    = q.rresp;
    assign chan_out_pin_o = out_lvl;
    assign irq_req        = ch_ovf;

endmodule // tae_top

// [sim/tae_monitor.sv]
// Port checker for the timer / event counter top.
// Assumes a bind onto tae_top; sees only its ports.
`timescale 1ns/1ns
module tae_mon (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [2:0]  chan_out_pin_o,
    input wire logic [2:0]  irq_req
);
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Past guard keeps pre-reset levels out of the toggle check
    AST_OUT_ON_WRAP: assert property ($past(aresetn) |->
        ((chan_out_pin_o ^ $past(chan_out_pin_o)) & ~irq_req) == 3'h0)
        else $error("pulse output moved without a wrap");
    AST_RD_LAT: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_WR_LAT: assert property (ce && s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_AW_FULL: assert property (ce && s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address slot not held");
    AST_W_FULL: assert property (ce && s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("data slot not held");
endmodule // tae_mon

bind tae_top tae_mon u_mon (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .chan_out_pin_o, .irq_req);

// [sim/tae_pin_model.sv]
// Far-side pin model: event pulses and a two-phase encoder.
// Assumes the block synchronises pins; levels move after aclk edges.
`timescale 1ns/1ns
module tae_pin_model (
    input  wire logic       aclk,
    output logic      [2:0] in_pin,
    output logic      [2:0] dir_pin
);
    initial begin
        in_pin = 3'h0;
        dir_pin = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Four cycles per level so every edge clears the synchronisers
    task automatic hold();
        repeat (4) @(posedge aclk);
    endtask

    task automatic set_in(input int ch, input logic v);
        hold();
        in_pin[ch] <= v;
    endtask

    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            set_in(ch, 1'b1);
            set_in(ch, 1'b0);
        end
        hold();
    endtask

    // Second phase drives the out pin as an input; only the wanted edge counts
    task automatic quad(input int n, input logic up);
        repeat (n) begin
            hold();
            dir_pin[2] <= up;
            set_in(2, 1'b1);
            hold();
            dir_pin[2] <= !up;
            set_in(2, 1'b0);
        end
        hold();
    endtask
endmodule // tae_pin_model

// [sim/tb.sv]
// Self-checking bench for the timer / event counter over AXI4-Lite.
// Assumes tae_top, tae_pin_model and the bound checker are compiled.
`timescale 1ns/1ns
module tb;
    logic        aclk, aresetn, subclk, bovf, ce;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  in_pin, dir_pin, pin_i, pin_o, oe, irq_req;
    int          irqs[3];
    int          ic;
    int          miscompares;
    int          n_checks;
    int          dv[4] = '{1, 8, 32, 320};

    always #2 aclk = ~aclk;
    always #20 subclk = ~subclk;
    assign pin_i = (oe & pin_o) | (~oe & dir_pin);

    tae_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chan_in_pin(in_pin), .chan_out_pin_i(pin_i),
        .chan_out_pin_o(pin_o), .chan_out_pin_oe(oe), .subclk(subclk),
        .second_b_group_timer_ovf(bovf), .irq_req(irq_req));
    tae_pin_model m (.aclk(aclk), .in_pin(in_pin), .dir_pin(dir_pin));

    always @(negedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            if (aresetn === 1'b1 && irq_req[i] === 1'b1) irqs[i]++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Ready is sampled mid-cycle; it comes from registers only
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            pa = pa && !awready;
            pw = pw && !wready;
            @(posedge aclk);
            if (!pa) awvalid <= 1'b0;
            if (!pw) wvalid <= 1'b0;
        end
        // Late bready makes the response wait a cycle
        repeat (2) @(posedge aclk);
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        rready <= 1'b1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // Cycles between two wraps, and the pulse output flips once
    task automatic per(input int ch, input int e);
        int n;
        logic o;
        n = 0;
        do @(negedge aclk); while (irq_req[ch] !== 1'b1);
        o = pin_o[ch];
        do begin
            @(negedge aclk);
            n++;
        end while (irq_req[ch] !== 1'b1);
        chk(32'(n), 32'(e));
        chk(32'(pin_o[ch] ^ o), 32'h1);
        @(posedge aclk);
    endtask

    task automatic ev(input int ch, input logic [11:0] md, input logic [15:0] rl,
                      input int n, input logic [15:0] e, input int ni);
        int i0;
        logic o;
        logic [7:0] a;
        a = 8'(16 * ch);
        wr(8'h30, 32'h0);
        wr(a, 32'(md));
        wr(a + 8'h4, 32'(rl));
        i0 = irqs[ch];
        o = pin_o[ch];
        wr(8'h30, 32'(1 << ch));
        if (md[6:5] == 2'h1) begin
            repeat (n) begin
                @(posedge aclk);
                bovf <= 1'b1;
                @(posedge aclk);
                bovf <= 1'b0;
            end
        end else begin
            m.pulses(ch, n);
        end
        repeat (8) @(posedge aclk);
        rd(a + 8'h4, 32'(e));
        chk(32'(irqs[ch] - i0), 32'(ni));
        chk(32'(pin_o[ch] ^ o), 32'(ni & 1));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        miscompares++;
        final_report();
    end

    initial begin
        aclk = 1'b0;
        subclk = 1'b0;
        aresetn = 1'b0;
        bovf = 1'b0;
        ce = 1'b1;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h3c, 32'h0, 2'h2);
        wr(8'h3c, 32'h1, 2'h2);
        wr(8'h04, 32'h1234);
        repeat (20) @(posedge aclk);
        rd(8'h04, 32'h1234);
        m.set_in(0, 1'b1);
        m.hold();
        rd(8'h34, 32'h8);
        m.set_in(0, 1'b0);
        for (int s = 3; s >= 0; s--) begin
            wr(8'h30, 32'h0);
            wr(8'h00, 32'(12'h010 | (s << 5)));
            wr(8'h04, 32'h5);
            wr(8'h30, 32'h1);
            per(0, 6 * dv[s]);
        end
        wr(8'h04, 32'h9);
        per(0, 10);
        // Clock enable low freezes the running counter
        ic = irqs[0];
        ce <= 1'b0;
        repeat (40) @(posedge aclk);
        chk(32'(irqs[0] - ic), 32'h0);
        ce <= 1'b1;
        wr(8'h30, 32'h0);
        wr(8'h00, 32'h01c);
        chk(32'(oe), 32'h1);
        wr(8'h04, 32'h3);
        wr(8'h30, 32'h1);
        repeat (20) @(posedge aclk);
        rd(8'h04, 32'h3);
        m.set_in(0, 1'b1);
        per(0, 4);
        m.set_in(0, 1'b0);
        ev(1, 12'h111, 16'hfffd, 3, 16'hfffd, 1);
        ev(1, 12'h091, 16'h0002, 3, 16'h0002, 1);
        ev(1, 12'h511, 16'hfffe, 3, 16'h0001, 1);
        // Direction pin high must override the down bit
        m.dir_pin[1] <= 1'b1;
        ev(1, 12'h211, 16'h0005, 2, 16'h0007, 0);
        ev(1, 12'h131, 16'h0000, 2, 16'h0002, 0);
        ev(0, 12'h911, 16'h0000, 2, 16'h0002, 0);
        rd(8'h00, 32'h911);
        wr(8'h30, 32'h0);
        wr(8'h20, 32'h811);
        wr(8'h24, 32'h10);
        wr(8'h30, 32'h4);
        chk(32'(oe), 32'h3);
        m.quad(3, 1'b1);
        rd(8'h24, 32'h13);
        m.quad(1, 1'b0);
        rd(8'h24, 32'h12);
        final_report();
    end
endmodule // tb
